// >>> rtl/async_serial_transmitter.v
// Asynchronous serial transmitter with AXI4-Lite register port.
// Assumes baud_tick is a one-cycle pulse from a separate baud-rate generator.
`timescale 1ns/10ps
`include "async_tx_defines.vh"
module async_serial_transmitter (
    input wire core_clk,
    input wire rstn,
    input wire baud_tick,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg tx_out_r,
    output reg tx_oe_r,
    output reg tx_irq_r
);
    // =================================================================
    // Registers
    reg tx_ninth_bit_r;
    reg sync_mode_r;
    reg transmitter_enable_r;
    reg nine_bit_tx_select_r;
    reg serial_port_enable_r;
    reg tx_invert_select_r;
    reg [2:0] irq_en_r;
    reg [8:0] tx_holding_buffer_r;
    reg pending_r;
    reg [3:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg w_have_r;
    reg [3:0] w_strb_r;

    wire busy;
    wire line;
    wire hold;
    wire load;
    wire do_write;
    wire tx_buffer_empty_flag;
    wire shifter_empty_flag;
    wire async_mode;

    function [7:0] merge_byte;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge_byte = strb[0] ? data[7:0] : old;
        end
    endfunction

    // =================================================================
    // Write channel
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =================================================================
    // Control registers
    wire [7:0] stc_new;
    wire [7:0] stc_old;
    wire [7:0] bc_new;
    wire [7:0] ic_new;
    wire hb_write;
    assign stc_old = {serial_port_enable_r, nine_bit_tx_select_r, transmitter_enable_r,
                      sync_mode_r, 3'h0, tx_ninth_bit_r};
    assign stc_new = merge_byte(stc_old, w_data_r, w_strb_r);
    assign bc_new = merge_byte({3'h0, tx_invert_select_r, 4'h0}, w_data_r, w_strb_r);
    assign ic_new = merge_byte({5'h0, irq_en_r}, w_data_r, w_strb_r);
    assign hb_write = do_write && aw_addr_r == `OFS_TX_HOLDING_BUFFER && w_strb_r[0];

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_ninth_bit_r <= 1'b0;
            sync_mode_r <= 1'b0;
            transmitter_enable_r <= 1'b0;
            nine_bit_tx_select_r <= 1'b0;
            serial_port_enable_r <= 1'b0;
            tx_invert_select_r <= 1'b0;
            irq_en_r <= `RST_IRQ_CONTROL;
        end else if (do_write) begin
            case (aw_addr_r)
                `OFS_TX_STATUS_CONTROL: begin
                    // Flag and shifter-empty bits take no write
                    tx_ninth_bit_r <= stc_new[`BIT_TX_NINTH_BIT];
                    sync_mode_r <= stc_new[`BIT_SYNC_MODE];
                    transmitter_enable_r <= stc_new[`BIT_TX_ENABLE];
                    nine_bit_tx_select_r <= stc_new[`BIT_TX9];
                    serial_port_enable_r <= stc_new[`BIT_PORT_ENABLE];
                end
                `OFS_BAUD_CONTROL: begin
                    tx_invert_select_r <= bc_new[`BIT_TX_INVERT];
                end
                `OFS_IRQ_CONTROL: begin
                    irq_en_r <= ic_new[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // =================================================================
    // Holding buffer and transfer to the shifter
    assign load = pending_r && !busy && transmitter_enable_r;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_holding_buffer_r <= 9'h0;
            pending_r <= 1'b0;
        end else if (!transmitter_enable_r) begin
            pending_r <= 1'b0;
        end else if (hb_write) begin
            tx_holding_buffer_r <= {tx_ninth_bit_r, w_data_r[7:0]};
            pending_r <= 1'b1;
        end else if (load) begin
            pending_r <= 1'b0;
        end
    end

    tx_shifter u_shifter (
        .core_clk(core_clk),
        .rstn(rstn),
        .baud_tick(baud_tick),
        .load(load),
        .load_data(tx_holding_buffer_r),
        .nine_bit(nine_bit_tx_select_r),
        .busy_r(busy),
        .line_r(line)
    );

    flag_delay u_flag_delay (
        .core_clk(core_clk),
        .rstn(rstn),
        .write_pulse(hb_write),
        .hold_r(hold)
    );

    // =================================================================
    // Status flags
    // Flag stays at its old value until the fourth cycle after a write
    reg flag_view_r;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_view_r <= 1'b0;
        end else if (!hold) begin
            flag_view_r <= transmitter_enable_r && !(pending_r && busy);
        end
    end
    assign tx_buffer_empty_flag = flag_view_r;
    assign shifter_empty_flag = !busy && !load;
    assign async_mode = !sync_mode_r;

    // =================================================================
    // Line output and interrupt
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_out_r <= 1'b1;
            tx_oe_r <= 1'b0;
            tx_irq_r <= 1'b0;
        end else begin
            tx_oe_r <= serial_port_enable_r && transmitter_enable_r;
            tx_out_r <= line ^ (tx_invert_select_r && async_mode);
            tx_irq_r <= tx_buffer_empty_flag && (&irq_en_r);
        end
    end

    // =================================================================
    // Read channel
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h0;
        case (s_axi_araddr)
            `OFS_TX_STATUS_CONTROL: begin
                rd_word[7:0] = stc_old;
                rd_word[`BIT_SHIFTER_EMPTY] = shifter_empty_flag;
            end
            `OFS_BAUD_CONTROL: begin
                rd_word[`BIT_TX_INVERT] = tx_invert_select_r;
            end
            `OFS_IRQ_CONTROL: begin
                rd_word[2:0] = irq_en_r;
                rd_word[`BIT_TX_FLAG] = tx_buffer_empty_flag;
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// >>> rtl/async_tx_defines.vh
// Constants for the asynchronous serial transmitter: register map, fields, timing.
// Assumes a 32-bit AXI4-Lite register port and a 50 MHz core clock.
`ifndef ASYNC_TX_DEFINES_VH
`define ASYNC_TX_DEFINES_VH

// =====================================================================
// Register byte offsets
`define OFS_TX_STATUS_CONTROL 4'h0
`define OFS_TX_HOLDING_BUFFER 4'h4
`define OFS_BAUD_CONTROL 4'h8
`define OFS_IRQ_CONTROL 4'hc

// =====================================================================
// tx_status_control fields
`define BIT_TX_NINTH_BIT 0
`define BIT_SHIFTER_EMPTY 1
`define BIT_SYNC_MODE 4
`define BIT_TX_ENABLE 5
`define BIT_TX9 6
`define BIT_PORT_ENABLE 7
// baud_control field
`define BIT_TX_INVERT 4
// irq_control fields
`define BIT_TX_IRQ_EN 0
`define BIT_PERIPH_IRQ_EN 1
`define BIT_GLOBAL_IRQ_EN 2
`define BIT_TX_FLAG 3

// =====================================================================
// Reset values
`define RST_TX_STATUS_CONTROL 8'h02
`define RST_BAUD_CONTROL 8'h00
`define RST_IRQ_CONTROL 3'h0

// =====================================================================
// Timing and bus response codes
`define FLAG_DELAY_CYCLES 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> rtl/tx_shifter.v
// Frame shifter: start bit, eight or nine data bits LSb first, one stop bit.
// Assumes a one-cycle baud tick enable and a load pulse only while idle.
`timescale 1ns/10ps
module tx_shifter (
    input wire core_clk,
    input wire rstn,
    input wire baud_tick,
    input wire load,
    input wire [8:0] load_data,
    input wire nine_bit,
    output reg busy_r,
    output reg line_r
);
    // Start, data, stop held in one shift word; no address reaches it
    reg [10:0] shift_r;
    reg [3:0] bits_left_r;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= 11'h7ff;
            bits_left_r <= 4'h0;
            busy_r <= 1'b0;
            line_r <= 1'b1;
        end else if (load) begin
            // Eight-bit frames put the stop bit where the ninth bit would sit
            if (nine_bit) begin
                shift_r <= {1'b1, load_data, 1'b0};
            end else begin
                shift_r <= {2'b11, load_data[7:0], 1'b0};
            end
            bits_left_r <= nine_bit ? 4'hb : 4'ha;
            busy_r <= 1'b1;
        end else if (busy_r && baud_tick) begin
            line_r <= shift_r[0];
            shift_r <= {1'b1, shift_r[10:1]};
            bits_left_r <= bits_left_r - 4'h1;
        end else if (busy_r && bits_left_r == 4'h0) begin
            busy_r <= 1'b0;
        end else if (!busy_r) begin
            line_r <= 1'b1;
        end
    end
endmodule

// >>> rtl/flag_delay.v
// Delays the view of a holding-buffer write on the buffer-empty flag.
// Assumes the write pulse is one cycle long.
`timescale 1ns/10ps
`include "async_tx_defines.vh"
module flag_delay (
    input wire core_clk,
    input wire rstn,
    input wire write_pulse,
    output reg hold_r
);
    reg [1:0] cnt_r;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 2'h0;
            hold_r <= 1'b0;
        end else if (write_pulse) begin
            cnt_r <= `FLAG_DELAY_CYCLES;
            hold_r <= 1'b1;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
            hold_r <= (cnt_r != 2'h1);
        end
    end
endmodule

// >>> test/async_tx_asserts.sv
// Port checker for the asynchronous serial transmitter.
// Bound to the top module by the bench; one clock domain.
`timescale 1ns/10ps
module async_tx_asserts (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic baud_tick,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic tx_out_r,
    input wire logic tx_oe_r,
    input wire logic tx_irq_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // =====================================================================
    // Recent register writes, which may move the line legally
    logic [3:0] wr_hist_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) wr_hist_r <= 4'h0;
        else wr_hist_r <= {wr_hist_r[2:0], s_axi_wvalid && s_axi_wready};
    end
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // =====================================================================
    // Properties
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response missing");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held too long");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response held too long");
    a_read_okay: assert property (s_rd_take ##0 s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == 2'h0)
        else $error("aligned read not okay");
    a_read_slverr: assert property (s_rd_take ##0 s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2)
        else $error("unaligned read not refused");
    a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("second write accepted");
    a_line_on_tick: assert property (
        $changed(tx_out_r) && wr_hist_r == 4'h0 |-> $past(baud_tick) || $past(baud_tick, 2))
        else $error("line moved without a bit tick");
    a_reset_idle: assert property ($rose(rstn) |-> tx_out_r && !tx_oe_r && !tx_irq_r)
        else $error("outputs not idle after reset");
endmodule

// >>> test/serial_rx_model.sv
// Remote asynchronous receiver watching the transmit line.
// Assumes the bench gives it the same bit tick, polarity and length.
`timescale 1ns/10ps
module serial_rx_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic baud_tick,
    input wire logic line,
    input wire logic inv,
    input wire logic nine,
    input wire logic listen,
    output logic [8:0] got,
    output int count,
    output int n_frame_err
);
    // =====================================================================
    // Sample one bit per tick, start bit first
    logic busy;
    int idx;
    logic [10:0] sh;
    wire logic lv = line ^ inv;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 0;
            idx <= 0;
            count <= 0;
            n_frame_err <= 0;
            got <= 9'h000;
        end else if (!busy) begin
            if (listen && lv == 1'b0) busy <= 1;
            idx <= 0;
        end else if (baud_tick) begin
            sh[idx] <= lv;
            idx <= idx + 1;
            if (idx == (nine ? 10 : 9)) begin
                busy <= 0;
                count <= count + 1;
                got <= nine ? sh[9:1] : {1'b0, sh[8:1]};
                if (sh[0] !== 1'b0 || lv !== 1'b1) n_frame_err <= n_frame_err + 1;
            end
        end
    end
endmodule

// >>> test/async_serial_transmitter_tb.sv
// Self-checking bench for the asynchronous serial transmitter.
// Drives the register port as bus master and listens with a receiver model.
`timescale 1ns/10ps
`include "async_tx_defines.vh"
module async_serial_transmitter_tb;
    logic core_clk = 0;
    logic rstn = 0;
    logic baud_tick = 0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, inv = 0, nine = 0, listen = 0;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [1:0] rsp;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic tx_out_r, tx_oe_r, tx_irq_r;
    logic [8:0] got;
    int rx_count, rx_err, n_mismatch = 0, comparisons = 0, cycles = 0, bt = 0;
    typedef struct {logic nine; logic d9; logic [7:0] d;} row_t;
    row_t rows[4] = '{'{0, 0, 8'ha5}, '{0, 1, 8'h3c}, '{1, 1, 8'h01}, '{1, 0, 8'hfe}};
    async_serial_transmitter i_async_serial_transmitter (.*);
    serial_rx_model i_serial_rx_model (.core_clk, .rstn, .baud_tick, .line(tx_out_r), .inv,
        .nine, .listen, .got, .count(rx_count), .n_frame_err(rx_err));
    always #10 core_clk = ~core_clk;
    // =====================================================================
    // Bit tick every eight cycles, and the run limit
    always @(posedge core_clk) begin
        bt <= (bt == 7) ? 0 : bt + 1;
        baud_tick <= (bt == 7);
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // =====================================================================
    // Register port master
    task wr(input logic [3:0] a, input logic [7:0] d);
        logic done;
        done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            done = s_axi_bvalid;
        end
        s_axi_bready <= 0;
        @(posedge core_clk);
    endtask
    task rdr(input logic [3:0] a);
        logic done;
        done = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            done = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
        end
        s_axi_rready <= 0;
        @(posedge core_clk);
    endtask
    task wait_rx(input int n);
        while (rx_count < n) @(posedge core_clk);
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1;
        @(posedge core_clk);
        rdr(`OFS_TX_STATUS_CONTROL); chk("status", 32'h02, rd);
        rdr(`OFS_BAUD_CONTROL); chk("baud_control", 32'h0, rd);
        rdr(`OFS_IRQ_CONTROL); chk("irq_control", 32'h0, rd);
        rdr(`OFS_TX_HOLDING_BUFFER); chk("holding", 32'h0, rd);
        rdr(4'h2); chk("rresp", `RESP_SLVERR, rsp);
        chk("idle line", 1, tx_out_r);
        wr(`OFS_TX_STATUS_CONTROL, 8'h80);
        wr(`OFS_TX_STATUS_CONTROL, 8'ha0);
        rdr(`OFS_IRQ_CONTROL); chk("flag", 32'h08, rd);
        wr(`OFS_IRQ_CONTROL, 8'h07);
        chk("irq", 1, tx_irq_r);
        wr(`OFS_IRQ_CONTROL, 8'h06);
        chk("irq", 0, tx_irq_r);
        rdr(`OFS_IRQ_CONTROL); chk("flag", 32'h0e, rd);
        listen <= 1;
        for (int i = 0; i < 4; i++) begin
            nine <= rows[i].nine;
            wr(`OFS_TX_STATUS_CONTROL, {1'b1, rows[i].nine, 5'h10, rows[i].d9});
            wr(`OFS_TX_HOLDING_BUFFER, rows[i].d);
            wait_rx(i + 1);
            chk("rx", rows[i].nine ? {rows[i].d9, rows[i].d} : {1'b0, rows[i].d}, got);
        end
        nine <= 0;
        wr(`OFS_TX_STATUS_CONTROL, 8'ha0);
        wr(`OFS_TX_HOLDING_BUFFER, 8'h55);
        wr(`OFS_TX_HOLDING_BUFFER, 8'h0f);
        rdr(`OFS_TX_STATUS_CONTROL); chk("status", 32'ha0, rd);
        rdr(`OFS_IRQ_CONTROL); chk("flag", 32'h06, rd);
        wr(`OFS_IRQ_CONTROL, 8'h0e);
        rdr(`OFS_IRQ_CONTROL); chk("flag", 32'h06, rd);
        wait_rx(5); chk("rx", 32'h55, got);
        wait_rx(6); chk("rx", 32'h0f, got);
        repeat (8) @(posedge core_clk);
        rdr(`OFS_TX_STATUS_CONTROL); chk("status", 32'ha2, rd);
        rdr(`OFS_IRQ_CONTROL); chk("flag", 32'h0e, rd);
        listen <= 0;
        wr(`OFS_BAUD_CONTROL, 8'h10);
        chk("inverted idle", 0, tx_out_r);
        inv <= 1;
        listen <= 1;
        wr(`OFS_TX_HOLDING_BUFFER, 8'hc3);
        wait_rx(7); chk("rx", 32'hc3, got);
        listen <= 0;
        wr(`OFS_TX_STATUS_CONTROL, 8'hb0);
        chk("sync line", 1, tx_out_r);
        chk("frame errors", 0, rx_err);
        print_verdict();
    end
endmodule
bind async_serial_transmitter async_tx_asserts i_async_tx_asserts (.core_clk, .rstn, .baud_tick,
    .s_axi_araddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp,
    .tx_out_r, .tx_oe_r, .tx_irq_r);
